// ==== src/pad_reset_default_state_control.sv ====
`timescale 1ns/100ps
`include "pad_consts.svh"

// How it works
// - video pads float in reset, then drive 0
// - low_extension_bit1 floats, input buffer normally off
// - strap buffers powered, sampled, powered down after reset
// - analog video off in reset, on once streaming
// - TDO floats except during JTAG shift out
// - TDI, TMS, TCK pull-ups always enabled
// - floating pads: input off, driver off
// - frame and row flags join autoconfiguration step
module pad_reset_default_state_control
	import pad_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        nrst_i,
	// core side video source
	input  wire logic        video_if_en_i,
	input  wire video_pad_s  video_core_i,
	input  wire logic        streaming_i,
	// jtag tap side
	input  wire logic        tdo_shift_en_i,
	input  wire logic        tdo_data_i,
	// strap pad inputs
	input  wire strap_s      strap_pad_i,
	// parallel video pads
	output video_pad_s       video_pad_o,
	output video_pad_s       video_pad_oe_o,
	// low extension bit1 pad
	output logic             low_extension_bit1_o,
	output logic             low_extension_bit1_oe_o,
	// strap input buffer power
	output logic             strap_ie_o,
	// analog video drivers
	output logic             analog_video_en_o,
	// jtag pads
	output logic             tdo_o,
	output logic             tdo_oe_o,
	output logic [2:0]       jtag_pullup_en_o,
	// autoconfiguration result
	output strap_s           strap_cfg_o,
	output logic             strap_done_o
);

	localparam int DAC_LAT = `DAC_EN_LAT;

	// default-state pad word; shared by the reset load and its check
	function automatic video_pad_s pad_idle();
		return '{`PAD_DEFAULT_LVL, {8{`PAD_DEFAULT_LVL}}, `PAD_DEFAULT_LVL};
	endfunction : pad_idle

	// autoconfiguration of the strap pads
	strap_sampler u_strap (
		.core_clk_i   (core_clk_i),
		.nrst_i       (nrst_i),
		.strap_pad_i  (strap_pad_i),
		.strap_ie_o   (strap_ie_o),
		.strap_cfg_o  (strap_cfg_o),
		.strap_done_o (strap_done_o)
	);

	// video pad enables: off in reset, on in default state
	// bit0 doubles as a strap, so it waits for the sample before driving
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			video_pad_oe_o <= '0;
		end else begin
			video_pad_oe_o.pixel_clock_out    <= 1'b1;
			video_pad_oe_o.parallel_data_out  <= '1;
			video_pad_oe_o.low_extension_bit0 <= strap_done_o;
		end
	end

	// video pad values: logic 0 until the interface is enabled
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i || !video_if_en_i) begin
			video_pad_o <= pad_idle();
		end else begin
			video_pad_o <= video_core_i;
		end
	end

	// bit1 never driven; its buffer only wakes for autoconfiguration
	always_ff @(posedge core_clk_i) begin
		low_extension_bit1_o    <= `PAD_DEFAULT_LVL;
		low_extension_bit1_oe_o <= 1'b0;
	end

	// analog drivers: sticky on from first streaming until reset
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			analog_video_en_o <= 1'b0;
		end else if (streaming_i) begin
			analog_video_en_o <= 1'b1;
		end
	end

	// tdo driven only while the tap shifts data out
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			tdo_oe_o <= 1'b0;
			tdo_o    <= `PAD_DEFAULT_LVL;
		end else begin
			tdo_oe_o <= tdo_shift_en_i;
			tdo_o    <= tdo_shift_en_i ? tdo_data_i : `PAD_DEFAULT_LVL;
		end
	end

	// pull-ups held on in reset as well, so floating tap pins read high
	always_ff @(posedge core_clk_i) begin
		jtag_pullup_en_o <= `PULLUP_ALL_ON;
	end

	property p_rst_hiz;
		@(posedge core_clk_i) disable iff (!nrst_i)
		$rose(nrst_i) |-> (video_pad_oe_o == '0) && !tdo_oe_o && !strap_ie_o;
	endproperty
	a_rst_hiz: assert property (p_rst_hiz) else $error("pads driven during reset");

	property p_default_low;
		@(posedge core_clk_i) disable iff (!nrst_i)
		$past(nrst_i) && !$past(video_if_en_i) |->
			video_pad_oe_o.pixel_clock_out && (video_pad_o == pad_idle());
	endproperty
	a_default_low: assert property (p_default_low) else $error("video pads not driven low");

	property p_bit0_after_sample;
		@(posedge core_clk_i) disable iff (!nrst_i)
		video_pad_oe_o.low_extension_bit0 |-> $past(strap_done_o);
	endproperty
	a_bit0_after_sample: assert property (p_bit0_after_sample) else $error("bit0 driven early");

	property p_bit1_hiz;
		@(posedge core_clk_i) disable iff (!nrst_i)
		$past(nrst_i) |-> !low_extension_bit1_oe_o;
	endproperty
	a_bit1_hiz: assert property (p_bit1_hiz) else $error("bit1 pad driven");

	property p_dac_off;
		@(posedge core_clk_i) disable iff (!nrst_i)
		$rose(nrst_i) |-> !analog_video_en_o;
	endproperty
	a_dac_off: assert property (p_dac_off) else $error("analog video on after reset");

	property p_dac_on;
		@(posedge core_clk_i) disable iff (!nrst_i)
		streaming_i |-> ##DAC_LAT analog_video_en_o ##1 analog_video_en_o;
	endproperty
	a_dac_on: assert property (p_dac_on) else $error("analog video not enabled");

	property p_tdo_shift;
		@(posedge core_clk_i) disable iff (!nrst_i)
		$past(nrst_i) |-> (tdo_oe_o == $past(tdo_shift_en_i));
	endproperty
	a_tdo_shift: assert property (p_tdo_shift) else $error("tdo enable mismatch");

	property p_pullup;
		@(posedge core_clk_i) disable iff (!nrst_i)
		$past(nrst_i) |-> (jtag_pullup_en_o == `PULLUP_ALL_ON);
	endproperty
	a_pullup: assert property (p_pullup) else $error("jtag pull-up dropped");

	property p_hiz_no_input;
		@(posedge core_clk_i) disable iff (!nrst_i)
		strap_done_o |-> !strap_ie_o && !low_extension_bit1_oe_o;
	endproperty
	a_hiz_no_input: assert property (p_hiz_no_input) else $error("floating pad still powered");

	// interface enabled: pads carry the core word one cycle later
	property p_video_follow;
		@(posedge core_clk_i) disable iff (!nrst_i)
		$past(nrst_i) && $past(video_if_en_i) |-> (video_pad_o == $past(video_core_i));
	endproperty
	a_video_follow: assert property (p_video_follow) else $error("video not following");

	// release in steps: enables off through reset, data pads on next, bit0 later
	sequence s_release;
		$rose(nrst_i);
	endsequence

	sequence s_drive_on;
		video_pad_oe_o.pixel_clock_out && (video_pad_oe_o.parallel_data_out == '1) &&
			!video_pad_oe_o.low_extension_bit0;
	endsequence

	property p_video_drive_on;
		@(posedge core_clk_i) disable iff (!nrst_i)
		s_release |=> s_drive_on;
	endproperty
	a_video_drive_on: assert property (p_video_drive_on) else $error("pads not enabled");

	property p_dac_sticky;
		@(posedge core_clk_i) disable iff (!nrst_i)
		analog_video_en_o |=> analog_video_en_o;
	endproperty
	a_dac_sticky: assert property (p_dac_sticky) else $error("analog video dropped");

	property p_dac_wait;
		@(posedge core_clk_i) disable iff (!nrst_i)
		$past(nrst_i) && !$past(streaming_i) && !$past(analog_video_en_o) |-> !analog_video_en_o;
	endproperty
	a_dac_wait: assert property (p_dac_wait) else $error("analog video on early");

	property p_tdo_data;
		@(posedge core_clk_i) disable iff (!nrst_i)
		$past(nrst_i) && $past(tdo_shift_en_i) |-> (tdo_o == $past(tdo_data_i));
	endproperty
	a_tdo_data: assert property (p_tdo_data) else $error("tdo data mismatch");

	// parked value low so a later enable never flashes stale data
	property p_tdo_idle;
		@(posedge core_clk_i) disable iff (!nrst_i)
		!tdo_oe_o |-> (tdo_o == `PAD_DEFAULT_LVL);
	endproperty
	a_tdo_idle: assert property (p_tdo_idle) else $error("tdo not parked low");

	property p_bit1_low;
		@(posedge core_clk_i) disable iff (!nrst_i)
		$past(nrst_i) |-> (low_extension_bit1_o == `PAD_DEFAULT_LVL);
	endproperty
	a_bit1_low: assert property (p_bit1_low) else $error("bit1 value not parked");

	property p_video_oe_on;
		@(posedge core_clk_i) disable iff (!nrst_i)
		$past(nrst_i) |->
			video_pad_oe_o.pixel_clock_out && (video_pad_oe_o.parallel_data_out == '1);
	endproperty
	a_video_oe_on: assert property (p_video_oe_on) else $error("video pads released");

endmodule : pad_reset_default_state_control

// ==== src/pad_consts.svh ====
`ifndef PAD_CONSTS_SVH
`define PAD_CONSTS_SVH

// core clock period, ns
`define CLK_PERIOD_NS      4
// least time the strap input buffers need after power-up, ns
`define STRAP_SETTLE_NS    100
// stages of the pad-input synchroniser
`define SYNC_STAGES        2
// level driven on a disabled output pad in the default state
`define PAD_DEFAULT_LVL    1'b0
// all three test-access pull-ups on
`define PULLUP_ALL_ON      3'h7
// settle counter width
`define SETTLE_CNT_W       8
// longest autoconfiguration run the checks allow, cycles
`define AUTOCFG_MAX_CYC    64
// cycles from streaming seen to analog drivers on
`define DAC_EN_LAT         1

`endif

// ==== src/pad_pkg.sv ====
package pad_pkg;

	// levels caught from the strap pads during autoconfiguration
	typedef struct packed {
		logic frame_active_flag;
		logic row_active_flag;
		logic low_extension_bit1;
		logic low_extension_bit0;
	} strap_s;

	// parallel video pad group: value and output enable travel together
	typedef struct packed {
		logic       pixel_clock_out;
		logic [7:0] parallel_data_out;
		logic       low_extension_bit0;
	} video_pad_s;

	// autoconfiguration sequence
	typedef enum logic [1:0] {
		ST_HOLD,
		ST_POWER_UP,
		ST_SAMPLE,
		ST_DONE
	} strap_state_e;

endpackage : pad_pkg

// ==== src/strap_sampler.sv ====
`timescale 1ns/100ps
`include "pad_consts.svh"

module strap_sampler
	import pad_pkg::*;
#(
	parameter int SETTLE_NS = `STRAP_SETTLE_NS
) (
	// clock and reset
	input  wire logic   core_clk_i,
	input  wire logic   nrst_i,
	// raw strap pad levels
	input  wire strap_s strap_pad_i,
	// buffer power and result
	output logic        strap_ie_o,
	output strap_s      strap_cfg_o,
	output logic        strap_done_o
);

	// least time rounds up to whole cycles, never under one
	localparam int SETTLE_RAW = (SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam int SETTLE_CYC = (SETTLE_RAW < 1) ? 1 : SETTLE_RAW;
	// the synchroniser delay is added so the sampled level is post-settle
	localparam logic [`SETTLE_CNT_W-1:0] WAIT_LAST =
		`SETTLE_CNT_W'(SETTLE_CYC + `SYNC_STAGES - 1);
	localparam int AUTOCFG_MAX = `AUTOCFG_MAX_CYC;

	strap_state_e               state_ff;
	logic [`SETTLE_CNT_W-1:0]   wait_ff;
	strap_s                     sync1_ff;
	strap_s                     sync2_ff;

	// two-flop synchroniser; only sync2 is read
	always_ff @(posedge core_clk_i) begin
		sync1_ff <= strap_pad_i;
		sync2_ff <= sync1_ff;
	end

	// power up, wait, sample, power down
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			state_ff <= ST_HOLD;
			wait_ff  <= '0;
		end else begin
			unique case (state_ff)
				ST_HOLD: begin
					state_ff <= ST_POWER_UP;
					wait_ff  <= '0;
				end
				ST_POWER_UP: begin
					if (wait_ff == WAIT_LAST) begin
						state_ff <= ST_SAMPLE;
					end else begin
						wait_ff <= wait_ff + 1'b1;
					end
				end
				ST_SAMPLE: state_ff <= ST_DONE;
				ST_DONE:   state_ff <= ST_DONE;
			endcase
		end
	end

	// buffers powered while in ST_POWER_UP and ST_SAMPLE; off in reset and once done
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			strap_ie_o <= 1'b0;
		end else begin
			strap_ie_o <= (state_ff == ST_HOLD) || (state_ff == ST_POWER_UP);
		end
	end

	// latched once, held until the next reset
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			strap_cfg_o  <= '0;
			strap_done_o <= 1'b0;
		end else if (state_ff == ST_SAMPLE) begin
			strap_cfg_o  <= sync2_ff;
			strap_done_o <= 1'b1;
		end
	end

	sequence s_powered;
		strap_ie_o && !strap_done_o;
	endsequence

	sequence s_finished;
		!strap_ie_o && strap_done_o;
	endsequence

	property p_autocfg;
		@(posedge core_clk_i) disable iff (!nrst_i)
		$rose(nrst_i) |=> s_powered ##[1:AUTOCFG_MAX] s_finished;
	endproperty
	a_autocfg: assert property (p_autocfg) else $error("strap autoconfig sequence broken");

	property p_all_straps_off;
		@(posedge core_clk_i) disable iff (!nrst_i)
		strap_done_o |-> !strap_ie_o;
	endproperty
	a_all_straps_off: assert property (p_all_straps_off) else $error("strap buffers left on");

	property p_cfg_hold;
		@(posedge core_clk_i) disable iff (!nrst_i)
		strap_done_o && $past(strap_done_o) |-> $stable(strap_cfg_o);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("strap config changed after latch");

endmodule : strap_sampler

// ==== tb/jtag_board_model.sv ====
`timescale 1ns/100ps

module jtag_board_model
	import pad_pkg::*;
(
	// clock and control
	input  wire logic   core_clk_i,
	input  wire logic   run_i,
	// board strap wiring and tap data
	input  wire strap_s strap_lvl_i,
	input  wire logic   tap_bit_i,
	// pins into the device
	output strap_s      strap_pad_o,
	output logic        tdo_shift_en_o,
	output logic        tdo_data_o
);
	// board-only pins, grounded for normal operation
	logic       trst_n_w;
	logic       field_lock_w;
	logic [1:0] analog_test_w;
	logic [3:0] tap_cnt_ff;

	assign trst_n_w      = 1'b0;
	assign field_lock_w  = 1'b0;
	assign analog_test_w = 2'h0;
	// strap resistors drive the pads all the time, following strap_lvl_i
	assign strap_pad_o = strap_lvl_i;

	initial begin
		tap_cnt_ff     = 4'h0;
		tdo_shift_en_o = 1'b0;
		tdo_data_o     = 1'b0;
	end

	// eight shift cycles of sixteen; idle data toggles so a stale bit never matches
	always @(negedge core_clk_i) begin
		tap_cnt_ff     <= run_i ? tap_cnt_ff + 4'h1 : 4'h0;
		tdo_shift_en_o <= run_i & tap_cnt_ff[3];
		tdo_data_o     <= tap_cnt_ff[3] ? tap_bit_i : ~tdo_data_o;
	end
endmodule : jtag_board_model

// ==== tb/pad_reset_default_state_control_tb_top.sv ====
`timescale 1ns/100ps
`include "pad_consts.svh"

module pad_reset_default_state_control_tb_top;
	import pad_pkg::*;
	logic core_clk_i = 1'b0, nrst_i = 1'b0, video_if_en_i = 1'b0, streaming_i = 1'b0;
	logic tap_bit = 1'b0, run = 1'b0, chk_on = 1'b0, an_m, tdoe_m, tdo_m;
	logic tdo_shift_en_i, tdo_data_i, low_extension_bit1_o, low_extension_bit1_oe_o;
	logic strap_ie_o, analog_video_en_o, tdo_o, tdo_oe_o, strap_done_o;
	logic [2:0] jtag_pullup_en_o;
	logic [31:0] seed = 32'haa98_46ef;
	video_pad_s video_core_i = '0, vp_m, video_pad_o, video_pad_oe_o;
	strap_s lvl = '0, strap_pad_i, strap_cfg_o, cfg_m;
	int k, num_errors = 0, n_compared = 0;
	// edges after release: buffers on below DONE_K, latch at DONE_K, bit0 driven after
	localparam int SETTLE_CYC = (`STRAP_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam int DONE_K = SETTLE_CYC + `SYNC_STAGES + 1;

	// 250 MHz core clock
	always #2 core_clk_i = ~core_clk_i;

	pad_reset_default_state_control dut_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
		.video_if_en_i(video_if_en_i), .video_core_i(video_core_i), .streaming_i(streaming_i),
		.tdo_shift_en_i(tdo_shift_en_i), .tdo_data_i(tdo_data_i), .strap_pad_i(strap_pad_i),
		.video_pad_o(video_pad_o), .video_pad_oe_o(video_pad_oe_o),
		.low_extension_bit1_o(low_extension_bit1_o),
		.low_extension_bit1_oe_o(low_extension_bit1_oe_o), .strap_ie_o(strap_ie_o),
		.analog_video_en_o(analog_video_en_o), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
		.jtag_pullup_en_o(jtag_pullup_en_o), .strap_cfg_o(strap_cfg_o),
		.strap_done_o(strap_done_o));

	jtag_board_model board_u (.core_clk_i(core_clk_i), .run_i(run), .strap_lvl_i(lvl),
		.tap_bit_i(tap_bit), .strap_pad_o(strap_pad_i), .tdo_shift_en_o(tdo_shift_en_i),
		.tdo_data_o(tdo_data_i));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs

	task automatic chk_bit(input string n, input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %b seen %b", n, e, g);
		end
	endtask : chk_bit

	task automatic chk_vec(input string n, input logic [9:0] e, input logic [9:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk_vec

	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results

	// reference model: k counts edges since reset release, -1 while in reset
	always @(posedge core_clk_i) begin
		if (!nrst_i) begin
			k = -1;
			an_m = 1'b0;
			vp_m = '0;
			tdoe_m = 1'b0;
			cfg_m = '0;
		end else begin
			k++;
			if (k == DONE_K)
				cfg_m = lvl;
			if (streaming_i)
				an_m = 1'b1;
			vp_m = video_if_en_i ? video_core_i : '0;
			tdoe_m = tdo_shift_en_i;
			tdo_m = tdo_data_i;
		end
	end

	// outputs settled since the rising edge; compare every cycle, tdo only while shifting
	always @(negedge core_clk_i) begin
		if (chk_on) begin
			chk_vec("video", vp_m, video_pad_o);
			chk_vec("video_oe", (k >= 0) ? {1'b1, 8'hff, k > DONE_K} : 10'h000, video_pad_oe_o);
			chk_bit("bit1", 1'b0, low_extension_bit1_o);
			chk_bit("bit1_oe", 1'b0, low_extension_bit1_oe_o);
			chk_bit("strap_ie", k >= 0 && k < DONE_K, strap_ie_o);
			chk_bit("done", k >= DONE_K, strap_done_o);
			chk_vec("cfg", {6'h00, cfg_m}, {6'h00, strap_cfg_o});
			chk_bit("analog", an_m, analog_video_en_o);
			chk_bit("tdo_oe", tdoe_m, tdo_oe_o);
			if (tdoe_m)
				chk_bit("tdo", tdo_m, tdo_o);
			chk_vec("pullup", 10'h007, {7'h00, jtag_pullup_en_o});
		end
	end

	// random stimulus; straps may only move once they have been latched
	task automatic drive(input int n, input logic strm, input logic chg);
		repeat (n) begin
			@(negedge core_clk_i);
			seed = xs(seed);
			video_core_i <= seed[9:0];
			video_if_en_i <= seed[12];
			tap_bit <= seed[13];
			streaming_i <= strm & (seed[23:19] == 5'h00);
			if (chg)
				lvl <= seed[27:24];
		end
	endtask : drive

	initial begin
		@(negedge core_clk_i);
		chk_on = 1'b1;
		for (int p = 0; p < 2; p++) begin
			lvl <= p ? 4'ha : 4'h5;
			nrst_i <= 1'b0;
			run <= 1'b0;
			drive(16, 1'b0, 1'b0);
			$display("test reset %0d done", p);
			nrst_i <= 1'b1;
			drive(40, 1'b0, 1'b0);
			$display("test autoconfig %0d done", p);
			run <= 1'b1;
			drive(300, 1'b1, 1'b1);
			$display("test streaming and tap %0d done", p);
		end
		results();
	end

	// watchdog: about 720 cycles are expected
	initial begin
		repeat (2000) @(posedge core_clk_i);
		num_errors++;
		results();
	end
endmodule : pad_reset_default_state_control_tb_top
